// File: hdl/acc_pkg.sv
// Purpose: shared constants for the converter calibration and clock divider control
// Assumes: 50 MHz system clock, 8-bit register address space
// Notes: timing figures kept in their own units, cycle counts derived from them
`default_nettype none
package acc_pkg;
    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 50_000_000; // system clock rate
    localparam int unsigned CAL_NOM_MS = 200; // nominal calibration time
    localparam int unsigned CAL_MAX_MS = 550; // longest calibration time
    localparam int unsigned CAL_NOM_CYC = CAL_NOM_MS * (CLK_HZ / 1000);
    localparam int unsigned CAL_MAX_CYC = CAL_MAX_MS * (CLK_HZ / 1000);
    localparam int unsigned RELOCK_US = 52; // dll relock time at full rate
    localparam int unsigned RELOCK_CYC = RELOCK_US * (CLK_HZ / 1_000_000);
    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_STATUS = 8'hb6; // calibration_status
    localparam logic [7:0] ADDR_CLKCTRL = 8'h60; // clock control
    localparam int unsigned ST_DONE_BIT = 0; // calibration done
    localparam int unsigned ST_LOCK_BIT = 1; // dll locked
    localparam int unsigned CC_RATIO_LSB = 0; // programmed ratio code, 2 bits
    localparam int unsigned CC_OVR_BIT = 2; // programmed ratio overrides pin
    localparam int unsigned CC_SLOW_BIT = 3; // dll slow range
    localparam int unsigned CC_SLIP_BIT = 4; // phase slip request, self clearing
    localparam logic [7:0] CLKCTRL_RESET = 8'h00; // fast range, pin ratio
    // ==========================================================
    // data and divider
    localparam logic [15:0] CAL_CODE = 16'hcccc; // output code during calibration
    typedef enum logic [1:0] {
        ACC_DIV1 = 2'b00,
        ACC_DIV2 = 2'b01,
        ACC_DIV4 = 2'b10
    } acc_div_t;
    typedef enum logic [1:0] {
        ACC_POR = 2'b00,
        ACC_HOLD = 2'b01,
        ACC_CAL = 2'b10,
        ACC_DONE = 2'b11
    } acc_state_t;
endpackage
`default_nettype wire

// File: hdl/acc_sync.sv
// Purpose: three-stage synchroniser for an asynchronous pin level
// Assumes: input is a slow level compared with clk_sys
// Notes: a change counts once stages two and three agree
`default_nettype none
module acc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic async_in,
    output logic sync_out
);
    // ==========================================================
    // capture chain
    logic s1_q, s2_q, s3_q, out_q; // chain stages and filtered result
    logic out_d; // next filtered value
    // keep the old value until the last two stages agree
    always_comb begin
        out_d = (s2_q == s3_q) ? s3_q : out_q;
    end
    // stage one feeds stage two only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end
    assign sync_out = out_q;
endmodule
`default_nettype wire

// File: hdl/acc_ctrl.sv
// Purpose: calibration sequencer and sample clock divider control of the converter
// Assumes: conversion clock is clk_sys, pins are asynchronous and pass acc_sync
// Notes: calib_reset_n is open drain, oe_n low means the block pulls it low
// Overview of operation
// - calibrate automatically once both supplies good
// - hold reset line low during power-on detection
// - start calibration on reset line rising edge
// - status bit zero shows calibration done flag
// - output code cccc while calibrating
// - divide by one: output clock always toggles
// - divide two/four: clock low during reset
// - calibration lasts 200ms nominal, 550ms most
// - decode three-level divide select pin
// - programmed ratio overrides the pin
// - dll relocks 52us after change at divide one, twice or four times that at two/four
// - dll slow or default fast range
// - phase slip aligns divider at two/four
// - sample clock is full, half or quarter rate
`default_nettype none
module acc_ctrl
    import acc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = acc_pkg::CAL_NOM_CYC, // calibration length
    parameter int unsigned RELOCK_CYCLES = acc_pkg::RELOCK_CYC // dll relock length
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic supplies_good, // analog and digital supplies above threshold
    input wire logic calib_reset_n_i, // level seen on the reset pin
    output logic calib_reset_n_o, // driven level, always low
    output logic calib_reset_n_oe_n, // low while the block pulls the pin low
    input wire logic div_pin_at_ground, // divide_select_pin tied to analog_ground_level
    input wire logic div_pin_at_supply, // divide_select_pin tied to analog_supply_level
    input wire logic divider_sync_reset, // aligns the divider phase
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // one-cycle read strobe
    output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire logic [15:0] conv_data, // conversion results from the core
    output logic [15:0] data_out, // parallel data outputs
    output logic sample_clock_out_p, // output clock
    output logic sample_clock_out_n, // output clock complement
    output logic sample_en, // one-cycle internal sample clock enable
    output logic dll_slow_range // dll range to the analog side
);
    import acc_pkg::*;
    // ==========================================================
    // pin synchronisers
    logic pwr_s, rstn_s, gnd_s, sup_s, dsr_s; // synchronised pin levels
    acc_sync #(.RESET_VAL(1'b0)) u_pwr (.clk_sys(clk_sys), .rst(rst), .async_in(supplies_good), .sync_out(pwr_s));
    acc_sync #(.RESET_VAL(1'b0)) u_rstn (.clk_sys(clk_sys), .rst(rst), .async_in(calib_reset_n_i),
        .sync_out(rstn_s));
    acc_sync #(.RESET_VAL(1'b0)) u_gnd (.clk_sys(clk_sys), .rst(rst), .async_in(div_pin_at_ground),
        .sync_out(gnd_s));
    acc_sync #(.RESET_VAL(1'b0)) u_sup (.clk_sys(clk_sys), .rst(rst), .async_in(div_pin_at_supply),
        .sync_out(sup_s));
    acc_sync #(.RESET_VAL(1'b0)) u_dsr (.clk_sys(clk_sys), .rst(rst), .async_in(divider_sync_reset),
        .sync_out(dsr_s));
    // ==========================================================
    // calibration sequencer
    acc_state_t st_q, st_d; // sequencer state
    logic [31:0] cal_cnt_q, cal_cnt_d; // calibration time counter
    logic rstn_q, rstn_d; // previous synchronised reset level for edge detect
    logic done_q, done_d; // calibration done flag
    logic oe_n_q, oe_n_d; // pin pull-down enable, low pulls
    logic rise; // rising edge of the reset line
    // next state of the sequencer
    always_comb begin
        st_d = st_q;
        cal_cnt_d = cal_cnt_q;
        done_d = done_q;
        oe_n_d = 1'b1;
        rstn_d = rstn_s;
        rise = rstn_s & ~rstn_q;
        case (st_q)
            // supplies not yet good: pull the line low
            ACC_POR: begin
                oe_n_d = pwr_s;
                if (pwr_s) begin
                    st_d = ACC_HOLD;
                end
            end
            // waiting for the line to rise
            ACC_HOLD: begin
                if (rise) begin
                    st_d = ACC_CAL;
                    cal_cnt_d = 32'h0000_0000;
                end
            end
            // calibrating for the set time
            ACC_CAL: begin
                if (!rstn_s) begin
                    st_d = ACC_HOLD; // restart on a new reset pulse
                end else if (cal_cnt_q >= CAL_CYCLES - 1) begin
                    st_d = ACC_DONE;
                    done_d = 1'b1;
                end else begin
                    cal_cnt_d = cal_cnt_q + 32'h0000_0001;
                end
            end
            // calibrated: a low pulse requests recalibration
            ACC_DONE: begin
                if (!rstn_s) begin
                    st_d = ACC_HOLD;
                end
            end
            default: begin
                st_d = ACC_POR;
            end
        endcase
        if (!pwr_s) begin
            st_d = ACC_POR; // supplies lost: back to power-on detection
            oe_n_d = 1'b0;
        end
        if (!rstn_s || !pwr_s) begin
            done_d = 1'b0;
        end
    end
    // sequencer registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= ACC_POR;
            cal_cnt_q <= 32'h0000_0000;
            rstn_q <= 1'b0;
            done_q <= 1'b0;
            oe_n_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cal_cnt_q <= cal_cnt_d;
            rstn_q <= rstn_d;
            done_q <= done_d;
            oe_n_q <= oe_n_d;
        end
    end
    assign calib_reset_n_o = 1'b0;
    assign calib_reset_n_oe_n = oe_n_q;
    // ==========================================================
    // registers
    logic [7:0] ctrl_q, ctrl_d; // clock control register
    logic [7:0] rdata_q, rdata_d; // read data
    logic slip_q, slip_d; // phase slip pulse
    logic lock_q; // dll locked
    // decode writes and reads
    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = rdata_q;
        slip_d = 1'b0;
        if (reg_wr && reg_addr == ADDR_CLKCTRL) begin
            ctrl_d = reg_wdata;
            ctrl_d[CC_SLIP_BIT] = 1'b0;
            slip_d = reg_wdata[CC_SLIP_BIT];
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: begin
                    rdata_d = 8'h00;
                    rdata_d[ST_DONE_BIT] = done_q;
                    rdata_d[ST_LOCK_BIT] = lock_q;
                end
                ADDR_CLKCTRL: begin
                    rdata_d = ctrl_q;
                end
                default: begin
                    rdata_d = 8'h00; // unmapped reads zero
                end
            endcase
        end
    end
    // register file
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q <= CLKCTRL_RESET;
            rdata_q <= 8'h00;
            slip_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            slip_q <= slip_d;
        end
    end
    assign reg_rdata = rdata_q;
    assign dll_slow_range = ctrl_q[CC_SLOW_BIT];
    // ==========================================================
    // divide ratio, divider and dll lock
    acc_div_t ratio, ratio_q; // selected ratio and its last value
    logic [1:0] dcnt_q, dcnt_d; // divider phase
    logic en_q, en_d; // sample enable
    logic clk_q, clk_d; // output clock level
    logic clk_n_q, clk_n_d; // complement output clock level, own flop
    logic [15:0] dout_q, dout_d; // output data
    logic [15:0] lk_q, lk_d; // relock counter
    logic lock_d; // next lock flag
    logic [1:0] top; // last divider phase
    logic [17:0] relock_len; // relock time scaled by the ratio
    // ratio selection and divider step
    always_comb begin
        if (ctrl_q[CC_OVR_BIT]) begin
            ratio = acc_div_t'(ctrl_q[CC_RATIO_LSB +: 2]);
        end else if (gnd_s) begin
            ratio = ACC_DIV2;
        end else if (sup_s) begin
            ratio = ACC_DIV4;
        end else begin
            ratio = ACC_DIV1;
        end
        case (ratio)
            ACC_DIV2: top = 2'd1;
            ACC_DIV4: top = 2'd3;
            default: top = 2'd0;
        endcase
        // lock time grows as the sample rate falls
        relock_len = (ratio == ACC_DIV4) ? 18'(RELOCK_CYCLES * 4) :
            (ratio == ACC_DIV2) ? 18'(RELOCK_CYCLES * 2) : 18'(RELOCK_CYCLES);
        dcnt_d = (dcnt_q >= top) ? 2'd0 : dcnt_q + 2'd1;
        if (slip_q && ratio != ACC_DIV1) begin
            dcnt_d = dcnt_q;
        end
        if (dsr_s) begin
            dcnt_d = 2'd0;
        end
        en_d = (dcnt_d == 2'd0);
        clk_d = en_d ? ~clk_q : clk_q;
        if (ratio != ACC_DIV1 && !rstn_s) begin
            clk_d = 1'b0;
        end
        clk_n_d = ~clk_d; // complement registered so the pin comes from a flop
        dout_d = (st_q == ACC_DONE) ? conv_data : CAL_CODE;
        lk_d = lk_q;
        lock_d = lock_q;
        if (ratio != ratio_q || dsr_s) begin
            lk_d = 16'h0000;
            lock_d = 1'b0;
        end else if (!lock_q) begin
            if (18'(lk_q) >= relock_len - 18'd1) begin
                lock_d = 1'b1;
            end else begin
                lk_d = lk_q + 16'h0001;
            end
        end
    end
    // divider registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ratio_q <= ACC_DIV1;
            dcnt_q <= 2'd0;
            en_q <= 1'b0;
            clk_q <= 1'b0;
            clk_n_q <= 1'b1;
            dout_q <= CAL_CODE;
            lk_q <= 16'h0000;
            lock_q <= 1'b0;
        end else begin
            ratio_q <= ratio;
            dcnt_q <= dcnt_d;
            en_q <= en_d;
            clk_q <= clk_d;
            clk_n_q <= clk_n_d;
            dout_q <= dout_d;
            lk_q <= lk_d;
            lock_q <= lock_d;
        end
    end
    assign sample_en = en_q;
    assign sample_clock_out_p = clk_q;
    assign sample_clock_out_n = clk_n_q;
    assign data_out = dout_q;
endmodule
`default_nettype wire

// File: sim/acc_ctrl_asserts.sv
// Purpose: port checks for the calibration and divider control
// Assumes: bound into every acc_ctrl
// Notes: cal_q counts cycles since the reset line went high
`default_nettype none
module acc_ctrl_asserts
    import acc_pkg::*;
#(
    parameter int unsigned CAL_CYCLES = 50,
    parameter int unsigned RELOCK_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic supplies_good,
    input wire logic calib_reset_n_i,
    input wire logic calib_reset_n_oe_n,
    input wire logic div_pin_at_ground,
    input wire logic div_pin_at_supply,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] conv_data,
    input wire logic [15:0] data_out,
    input wire logic sample_clock_out_p,
    input wire logic sample_en
);
    localparam int unsigned CAL_END = CAL_CYCLES + 8; // done must be visible by then
    int unsigned cal_q; // cycles since line high
    int unsigned cal_d;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ==========================================================
    // calibration age counter, zero while line low or supplies lost
    always_comb begin
        cal_d = cal_q;
        if (!calib_reset_n_i || !supplies_good) begin
            cal_d = 0;
        end else if (cal_q < CAL_END) begin
            cal_d = cal_q + 1;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cal_q <= 0;
        end else begin
            cal_q <= cal_d;
        end
    end
    // ==========================================================
    // properties
    AST_OE_POR: assert property (!supplies_good [*6] |-> !calib_reset_n_oe_n)
        else $error("line not pulled low before supplies good");
    AST_CAL_HOLD: assert property (cal_q != 0 && cal_q < CAL_CYCLES |-> data_out == CAL_CODE)
        else $error("calibration ended too soon");
    AST_CAL_END: assert property (cal_q == CAL_END |-> data_out == $past(conv_data))
        else $error("calibration not finished in time");
    AST_LINE_LOW: assert property (!calib_reset_n_i [*7] |-> data_out == CAL_CODE)
        else $error("results shown while line low");
    AST_STATUS_RSVD: assert property (reg_rd && reg_addr == ADDR_STATUS |=> reg_rdata[7:2] == 6'h00)
        else $error("status upper bits not zero");
    AST_DIV1_TOGGLE: assert property ((!div_pin_at_ground && !div_pin_at_supply) [*8]
        |-> sample_clock_out_p != $past(sample_clock_out_p))
        else $error("output clock stalled at divide one");
    AST_DIV2_GAP: assert property (div_pin_at_ground [*8] ##0 sample_en |=> !sample_en)
        else $error("back to back sample enables when divided");
    AST_DIV_HOLD_LOW: assert property ((div_pin_at_ground && !calib_reset_n_i) [*8]
        |-> !sample_clock_out_p)
        else $error("output clock not low during reset");
endmodule
bind acc_ctrl acc_ctrl_asserts #(.CAL_CYCLES(CAL_CYCLES), .RELOCK_CYCLES(RELOCK_CYCLES)) u_chk (.*);
`default_nettype wire

// File: sim/acc_host.sv
// Purpose: host side of the open-drain calibration reset line
// Assumes: line has a pull-up, low when either party pulls
// Notes: a request pulls the line low for LOW_CYC cycles
`default_nettype none
module acc_host #(
    parameter int LOW_CYC = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic recal_req,
    input wire logic dev_oe_n,
    output logic line
);
    int cnt_q; // cycles left of the low pulse
    int cnt_d;
    // pulse long enough to pass the pin filter, no serial traffic driven
    always_comb begin
        cnt_d = recal_req ? LOW_CYC : (cnt_q > 0 ? cnt_q - 1 : 0);
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    assign line = dev_oe_n && (cnt_q == 0);
endmodule
`default_nettype wire

// File: sim/acc_ctrl_tb.sv
// Purpose: self-checking bench of the calibration and divider control
// Assumes: acc_host resolves the reset line
// Notes: calibration and relock counts are shortened
`default_nettype none
module acc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;
    localparam int CAL = 50;
    localparam int RLK = 8;
    logic clk_sys = 1'b0, rst = 1'b1, sup = 1'b0, req = 1'b0, gnd = 1'b0, vdd = 1'b0;
    logic dsr = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v;
    logic [15:0] conv = 16'h1234, dout;
    logic line, drv, oe_n, op, opn, sen, slow;
    int bad_count = 0, compares = 0, n;
    acc_ctrl #(.CAL_CYCLES(CAL), .RELOCK_CYCLES(RLK)) uut (
        .clk_sys(clk_sys), .rst(rst), .supplies_good(sup), .calib_reset_n_i(line),
        .calib_reset_n_o(drv), .calib_reset_n_oe_n(oe_n), .div_pin_at_ground(gnd),
        .div_pin_at_supply(vdd), .divider_sync_reset(dsr), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wd), .reg_rd(rd), .reg_rdata(rdata), .conv_data(conv), .data_out(dout),
        .sample_clock_out_p(op), .sample_clock_out_n(opn), .sample_en(sen), .dll_slow_range(slow));
    acc_host u_host (.clk_sys(clk_sys), .rst(rst), .recal_req(req), .dev_oe_n(oe_n), .line(line));
    // ==========================================================
    // helpers, all entered just after a falling edge
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rreg(input logic [7:0] a);
        addr = a;
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
        @(negedge clk_sys);
        v = rdata;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk_sys);
        wr = 1'b0;
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    // counts sample enables, or output clock toggles when tog is set
    task automatic cnt_en(input int cyc, input bit tog, output int c);
        logic p;
        c = 0;
        p = op;
        repeat (cyc) begin
            @(negedge clk_sys);
            c += tog ? int'(op !== p) : int'(sen === 1'b1);
            p = op;
        end
    endtask
    task automatic pulse_recal;
        req = 1'b1;
        @(negedge clk_sys);
        req = 1'b0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_por;
        wait_cyc(8);
        chk("line pull", 16'h0, {15'h0, oe_n});
        chk("drive level", 16'h0, {15'h0, drv});
        chk("cal code", CAL_CODE, dout);
        sup = 1'b1;
        wait_cyc(12);
        chk("cal running", CAL_CODE, dout);
        wait_cyc(CAL + 8);
        rreg(ADDR_STATUS);
        chk("done", 16'h1, {15'h0, v[0]});
        chk("results", conv, dout);
        rreg(8'h11);
        chk("unmapped", 16'h0, {8'h00, v});
    endtask
    task automatic t_recal;
        gnd = 1'b1;
        wait_cyc(12);
        pulse_recal();
        wait_cyc(6);
        chk("clk low", 16'h0, {15'h0, op});
        chk("recal code", CAL_CODE, dout);
        rreg(ADDR_STATUS);
        chk("done cleared", 16'h0, {15'h0, v[0]});
        wait_cyc(10);
        rreg(ADDR_STATUS);
        chk("done running", 16'h0, {15'h0, v[0]});
        wait_cyc(CAL + 8);
        rreg(ADDR_STATUS);
        chk("status", 16'h3, {8'h00, v});
    endtask
    task automatic t_div;
        gnd = 1'b0;
        wait_cyc(10);
        pulse_recal();
        cnt_en(8, 1'b1, n);
        chk("div1 toggles", 16'd8, 16'(n));
        chk("clk complement", {15'h0, ~op}, {15'h0, opn});
        gnd = 1'b1;
        wait_cyc(10);
        cnt_en(16, 1'b0, n);
        chk("div2 enables", 16'd8, 16'(n));
        gnd = 1'b0;
        vdd = 1'b1;
        wait_cyc(10);
        cnt_en(16, 1'b0, n);
        chk("div4 enables", 16'd4, 16'(n));
        dsr = 1'b1;
        wait_cyc(4);
        dsr = 1'b0;
        wait_cyc(10);
        cnt_en(16, 1'b0, n);
        chk("sync enables", 16'd4, 16'(n));
    endtask
    task automatic t_ovr;
        vdd = 1'b0;
        gnd = 1'b1;
        wait_cyc(10);
        wreg(ADDR_CLKCTRL, 8'h06);
        wait_cyc(10);
        cnt_en(16, 1'b0, n);
        chk("override enables", 16'd4, 16'(n));
        wreg(ADDR_CLKCTRL, 8'h16);
        rreg(ADDR_CLKCTRL);
        chk("slip reads zero", 16'h06, {8'h00, v});
        wreg(ADDR_CLKCTRL, 8'h0e);
        wait_cyc(RLK * 4 + 8);
        chk("slow range", 16'h1, {15'h0, slow});
        rreg(ADDR_STATUS);
        chk("relocked", 16'h3, {8'h00, v});
        wreg(ADDR_CLKCTRL, 8'h00);
        wait_cyc(2);
        chk("fast range", 16'h0, {15'h0, slow});
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        wait_cyc(6);
        rst = 1'b0;
        t_por();
        t_recal();
        t_div();
        t_ovr();
        test_done();
    end
    // whole run is under 1000 cycles, so 100 us means a hang
    initial begin
        #100us;
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
